// ---- rtl/interval_alarm_timer.sv ----
// Summary of operation
// - counting starts late after clear release, debounce
// - count begins only after debounced clear rises
// - selects latched at release, later changes ignored
// - two select pins choose one of four intervals
// - alarm mode is a build-time parameter
// - pulse mode: pulse on match, restart count
// - handshake mode: hold alarm level, freeze count
// - handshake: clear low drops alarm and clears, release restarts
// - clear low before match clears the counter
// - push-pull variant drives alarm active high
// - select codes map to 60, 10, 30, 1 s
// - pulse width 7.8 ms drain, 125 ms push-pull
// - clear filtered by three samples at 8 hz
// - interval counter is 24-bit binary up-counter
`default_nettype none
module interval_alarm_timer #(
    parameter interval_timer_pkg::alarm_mode_t MODE =
        interval_timer_pkg::MODE_PULSE,
    parameter bit PUSH_PULL = 1'b0,
    parameter int unsigned TICK8_CYC = interval_timer_pkg::TICK8_CYC,
    parameter int unsigned PULSE_OD_CYC = interval_timer_pkg::PULSE_OD_CYC,
    parameter int unsigned PULSE_PP_CYC = interval_timer_pkg::PULSE_PP_CYC,
    parameter int unsigned COUNT_W = interval_timer_pkg::COUNT_W
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CLEAR_N,
    input wire logic INTERVAL_SEL0,
    input wire logic INTERVAL_SEL1,
    output logic ALARM_O,
    output logic ALARM_OE_N,
    input wire logic [interval_timer_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // interval in seconds for a select code
    function automatic logic [COUNT_W-1:0] interval_of(
        input logic [1:0] sel
    );
        logic [COUNT_W-1:0] r;
        case (sel)
            2'b00: r = COUNT_W'(interval_timer_pkg::IVAL_SEL00);
            2'b01: r = COUNT_W'(interval_timer_pkg::IVAL_SEL01);
            2'b10: r = COUNT_W'(interval_timer_pkg::IVAL_SEL10);
            default: r = COUNT_W'(interval_timer_pkg::IVAL_SEL11);
        endcase
        return r;
    endfunction : interval_of

    // pulse length follows the output variant
    localparam int unsigned PULSE_CYC =
        PUSH_PULL ? PULSE_PP_CYC : PULSE_OD_CYC;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0] presc_q; // free-running 8 hz divider
    logic tick8; // one-cycle 8 hz strobe
    logic [interval_timer_pkg::SUBTICK_W-1:0] subtick_q; // ticks in second
    logic sec_tick; // one-cycle seconds strobe, only while counting
    logic clr_level; // filtered clear, high = released
    logic clr_rise; // filtered release
    logic clr_fall; // filtered clear assertion
    interval_timer_pkg::timer_state_t state_q; // sequencing
    interval_timer_pkg::timer_state_t state_d;
    logic [1:0] sel_q; // select code latched at release
    logic [COUNT_W-1:0] count_q; // seconds since start
    logic [COUNT_W-1:0] count_d;
    logic match; // count reached chosen interval
    logic [31:0] pulse_q; // cycles left of the alarm pulse
    logic toggle_q; // level for the toggle variant
    logic alarm_act; // alarm asserted, polarity neutral
    interval_timer_pkg::events_t status_q; // sticky events
    interval_timer_pkg::events_t mask_q; // interrupt enables
    interval_timer_pkg::events_t evt; // this cycle's events
    logic [31:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // time base

    // one divider feeds both the debounce sampler and the seconds count
    always_ff @(posedge MCLK) begin
        if (RST) begin
            presc_q <= '0;
        end else if (presc_q == 32'(TICK8_CYC - 1)) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 32'd1;
        end
    end

    assign tick8 = (presc_q == 32'(TICK8_CYC - 1));

    // eight sampler ticks make one second; restarted at each release so
    // the first second is not shortened by a stale phase (up to one tick
    // of slip remains, well inside the documented first-alarm lateness)
    always_ff @(posedge MCLK) begin
        if (RST) begin
            subtick_q <= '0;
        end else if (state_q != interval_timer_pkg::ST_COUNT) begin
            subtick_q <= '0;
        end else if (tick8) begin
            subtick_q <= subtick_q + 1'b1;
        end
    end

    assign sec_tick = tick8 && (state_q == interval_timer_pkg::ST_COUNT) &&
        (subtick_q == interval_timer_pkg::SUBTICK_W'(
            interval_timer_pkg::TICKS_PER_SEC - 1));

    ////////////////////////////////////////////////////////////////////////
    // clear input filter

    clear_debounce #(
        .SAMPLES(interval_timer_pkg::DEBOUNCE_SAMPLES)
    ) u_debounce (
        .clk(MCLK),
        .rst(RST),
        .sample_tick(tick8),
        .clear_n_pin(CLEAR_N),
        .level_q(clr_level),
        .rise(clr_rise),
        .fall(clr_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    assign match = (state_q == interval_timer_pkg::ST_COUNT) &&
        (count_q == interval_of(sel_q));

    // next state; a filtered clear overrides everything else
    always_comb begin
        state_d = state_q;
        case (state_q)
            interval_timer_pkg::ST_CLEARED: begin
                // wait for the filtered release, not the raw pin
                if (clr_rise) begin
                    state_d = interval_timer_pkg::ST_COUNT;
                end
            end
            interval_timer_pkg::ST_COUNT: begin
                if (match && MODE == interval_timer_pkg::MODE_HANDSHAKE) begin
                    state_d = interval_timer_pkg::ST_HOLD;
                end
            end
            interval_timer_pkg::ST_HOLD: begin
                // only a clear from the host leaves the hold
                state_d = interval_timer_pkg::ST_HOLD;
            end
            default: begin
                state_d = interval_timer_pkg::ST_CLEARED;
            end
        endcase
        // the release cycle itself still shows the filtered level low
        if (clr_fall || (!clr_level && !clr_rise)) begin
            state_d = interval_timer_pkg::ST_CLEARED;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= interval_timer_pkg::ST_CLEARED;
        end else begin
            state_q <= state_d;
        end
    end

    // select pins are sampled once, on the filtered release only
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sel_q <= 2'b00;
        end else if (state_q == interval_timer_pkg::ST_CLEARED &&
            clr_rise) begin
            sel_q <= {INTERVAL_SEL0, INTERVAL_SEL1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interval counter

    // the match is seen the cycle after the increment, so a seconds tick
    // and a match never fall in the same cycle
    always_comb begin
        count_d = count_q;
        if (state_q == interval_timer_pkg::ST_COUNT) begin
            if (match) begin
                if (MODE != interval_timer_pkg::MODE_HANDSHAKE) begin
                    count_d = '0;
                end
            end else if (sec_tick) begin
                count_d = count_q + 1'b1;
            end
        end
        if (state_d == interval_timer_pkg::ST_CLEARED) begin
            count_d = '0;
        end
    end

    // in hold the count just stays where the match left it
    always_ff @(posedge MCLK) begin
        if (RST) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm generation

    // pulse width timer, reloaded on every match in pulse mode
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pulse_q <= '0;
        end else if (state_d == interval_timer_pkg::ST_CLEARED) begin
            pulse_q <= '0;
        end else if (match && MODE == interval_timer_pkg::MODE_PULSE) begin
            pulse_q <= 32'(PULSE_CYC);
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - 32'd1;
        end
    end

    // toggle variant: level flips on every match, count restarts
    always_ff @(posedge MCLK) begin
        if (RST) begin
            toggle_q <= 1'b0;
        end else if (state_d == interval_timer_pkg::ST_CLEARED) begin
            toggle_q <= 1'b0;
        end else if (match && MODE == interval_timer_pkg::MODE_TOGGLE) begin
            toggle_q <= ~toggle_q;
        end
    end

    // mode is a constant, so only one source is ever live
    assign alarm_act = (pulse_q != '0) || toggle_q ||
        (state_q == interval_timer_pkg::ST_HOLD);

    // pin: open-drain sinks low while active; push-pull is active high
    // and always drives, so its enable stays low
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ALARM_O <= 1'b0;
            ALARM_OE_N <= ~PUSH_PULL;
        end else if (PUSH_PULL) begin
            ALARM_O <= alarm_act;
            ALARM_OE_N <= 1'b0;
        end else begin
            ALARM_O <= 1'b0;
            ALARM_OE_N <= ~alarm_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events and interrupt

    always_comb begin
        evt.alarm = match;
        evt.cleared = clr_fall;
        evt.released = clr_rise;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            status_q <= interval_timer_pkg::EVT_RESET;
        end else if (REG_WR &&
            REG_ADDR == interval_timer_pkg::OFS_STATUS) begin
            status_q <= (status_q &
                ~REG_WDATA[interval_timer_pkg::EVT_W-1:0]) | evt;
        end else begin
            status_q <= status_q | evt;
        end
    end

    // mask register gates the interrupt line
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mask_q <= interval_timer_pkg::MASK_RESET;
        end else if (REG_WR && REG_ADDR == interval_timer_pkg::OFS_MASK) begin
            mask_q <= REG_WDATA[interval_timer_pkg::EVT_W-1:0];
        end
    end

    // registered level, so it lags a status change by one cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port

    // unmapped offsets read as zero
    always_comb begin
        rdata_d = 32'h00000000;
        case (REG_ADDR)
            interval_timer_pkg::OFS_STATUS: begin
                rdata_d = {29'h0, status_q};
            end
            interval_timer_pkg::OFS_MASK: begin
                rdata_d = {29'h0, mask_q};
            end
            interval_timer_pkg::OFS_COUNT: begin
                rdata_d = 32'(count_q);
            end
            interval_timer_pkg::OFS_INFO: begin
                // alarm, filtered clear, state, latched select
                rdata_d = {26'h0, alarm_act, clr_level, state_q, sel_q};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_d;
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

endmodule : interval_alarm_timer
`default_nettype wire

// ---- rtl/interval_timer_pkg.sv ----
`default_nettype none
package interval_timer_pkg;

    // clock and time base
    localparam int unsigned MCLK_PERIOD_NS = 100;
    localparam int unsigned TICK8_PERIOD_NS = 125_000_000;
    localparam int unsigned TICK8_CYC = TICK8_PERIOD_NS / MCLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_SEC = 8;
    localparam int unsigned SUBTICK_W = 3;

    // alarm pulse widths per output variant
    localparam int unsigned PULSE_OD_NS = 7_800_000;
    localparam int unsigned PULSE_PP_NS = 125_000_000;
    localparam int unsigned PULSE_OD_CYC = PULSE_OD_NS / MCLK_PERIOD_NS;
    localparam int unsigned PULSE_PP_CYC = PULSE_PP_NS / MCLK_PERIOD_NS;

    // debounce
    localparam int unsigned DEBOUNCE_SAMPLES = 3;

    // interval counter
    localparam int unsigned COUNT_W = 24;
    localparam logic [23:0] IVAL_SEL00 = 24'h00003c;
    localparam logic [23:0] IVAL_SEL01 = 24'h00000a;
    localparam logic [23:0] IVAL_SEL10 = 24'h00001e;
    localparam logic [23:0] IVAL_SEL11 = 24'h000001;

    // register map
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_MASK = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam logic [3:0] OFS_INFO = 4'hc;
    localparam int unsigned EVT_W = 3;
    localparam logic [2:0] EVT_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // alarm behaviour, fixed at build time
    typedef enum logic [1:0] {
        MODE_PULSE = 2'b00,
        MODE_HANDSHAKE = 2'b01,
        MODE_TOGGLE = 2'b10
    } alarm_mode_t;

    // timer sequencing
    typedef enum logic [1:0] {
        ST_CLEARED = 2'b00,
        ST_COUNT = 2'b01,
        ST_HOLD = 2'b10
    } timer_state_t;

    // sticky event bits, same layout for status and mask
    typedef struct packed {
        logic released;
        logic cleared;
        logic alarm;
    } events_t;

endpackage : interval_timer_pkg
`default_nettype wire

// ---- rtl/clear_debounce.sv ----
`default_nettype none
// three-sample filter on the active-low clear input
module clear_debounce #(
    parameter int unsigned SAMPLES = interval_timer_pkg::DEBOUNCE_SAMPLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_tick,
    input wire logic clear_n_pin,
    output logic level_q,
    output logic rise,
    output logic fall
);

    logic [SAMPLES-1:0] hist_q; // last samples, newest in bit 0

    // shift in one sample per 8 hz tick
    always_ff @(posedge clk) begin
        if (rst) begin
            hist_q <= '0;
        end else if (sample_tick) begin
            hist_q <= {hist_q[SAMPLES-2:0], clear_n_pin};
        end
    end

    // level moves only on a unanimous set of samples, so a glitch
    // shorter than two tick periods never changes it
    always_ff @(posedge clk) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (&hist_q) begin
            level_q <= 1'b1;
        end else if (~|hist_q) begin
            level_q <= 1'b0;
        end
    end

    // edges of the filtered level, one cycle each
    assign rise = (&hist_q) & ~level_q;
    assign fall = (~|hist_q) & level_q;

endmodule : clear_debounce
`default_nettype wire

// ---- verification/interval_alarm_timer_assertions.sv ----
`default_nettype none
// watches one timer instance from its pins and register port
module timer_checker #(
    parameter interval_timer_pkg::alarm_mode_t MODE =
        interval_timer_pkg::MODE_PULSE,
    parameter bit PUSH_PULL = 1'b0,
    parameter int unsigned TICK8_CYC = 4,
    parameter int unsigned PULSE_OD_CYC = 3,
    parameter int unsigned PULSE_PP_CYC = 5
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CLEAR_N,
    input wire logic ALARM_O,
    input wire logic ALARM_OE_N,
    input wire logic [interval_timer_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned PW = PUSH_PULL ? PULSE_PP_CYC : PULSE_OD_CYC;
    localparam int unsigned SEC = 8 * TICK8_CYC;
    // a clear held this long is seen by the filter whatever the phase
    localparam int unsigned CLR = 5 * TICK8_CYC;
    localparam bit PULSE = (MODE == interval_timer_pkg::MODE_PULSE);
    localparam bit HAND = (MODE == interval_timer_pkg::MODE_HANDSHAKE);
    logic act; // alarm active at the pin, either variant
    int unsigned run_q; // cycles the alarm has stood active
    int unsigned low_q; // cycles clear has been low
    int unsigned hi_q; // cycles clear has been high
    int unsigned up_q; // cycles since a sure clear, saturating
    assign act = PUSH_PULL ? ALARM_O : !ALARM_OE_N;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    // run lengths; a short clear glitch must not restart up_q
    always_ff @(posedge MCLK) begin
        run_q <= (act && !RST) ? run_q + 1 : 0;
        low_q <= (!CLEAR_N && !RST) ? low_q + 1 : 0;
        hi_q <= (CLEAR_N && !RST) ? hi_q + 1 : 0;
        if (RST || low_q >= CLR) begin
            up_q <= 0;
        end else if (up_q < SEC) begin
            up_q <= up_q + 1;
        end
    end
    sequence s_mask_off;
        REG_WR && REG_ADDR == interval_timer_pkg::OFS_MASK &&
            REG_WDATA[2:0] == 3'h0;
    endsequence
    a_od_never_high: assert property (!PUSH_PULL |-> !ALARM_O)
        else $error("drain variant drove high");
    a_pp_always_on: assert property (PUSH_PULL |-> !ALARM_OE_N)
        else $error("push-pull variant released pin");
    a_pulse_width: assert property (
        PULSE && $fell(act) && hi_q > 4 |-> run_q == PW)
        else $error("pulse width wrong");
    a_pulse_bounded: assert property (PULSE && act |-> run_q < PW)
        else $error("pulse too long");
    a_hold_level: assert property (
        HAND && act && hi_q >= 8 |=> act)
        else $error("held alarm dropped");
    a_clear_idle: assert property (low_q >= CLR |-> !act)
        else $error("alarm while cleared");
    a_late_first: assert property (up_q < SEC |-> !act)
        else $error("alarm too soon after release");
    a_rdata_one_cycle: assert property (!$past(REG_RD) |-> REG_RDATA == 0)
        else $error("read data outside its cycle");
    a_mask_quiet: assert property (s_mask_off |-> ##2 !IRQ)
        else $error("irq despite zero mask");
endmodule : timer_checker
bind interval_alarm_timer timer_checker #(.MODE(MODE), .PUSH_PULL(PUSH_PULL),
    .TICK8_CYC(TICK8_CYC), .PULSE_OD_CYC(PULSE_OD_CYC),
    .PULSE_PP_CYC(PULSE_PP_CYC)) timer_checker_inst (.MCLK(MCLK), .RST(RST),
    .CLEAR_N(CLEAR_N), .ALARM_O(ALARM_O), .ALARM_OE_N(ALARM_OE_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
`default_nettype wire

// ---- verification/host_model.sv ----
`default_nettype none
// host side: pull-up on the alarm line, clear driven on request
module host_model #(
    parameter bit PUSH_PULL = 1'b0,
    parameter int ACK_CYC = 24
) (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    input wire logic hold_clear, // bench holds clear low
    input wire logic auto_ack, // answer an alarm with a clear pulse
    output logic clear_n,
    output logic alarm_pin,
    output int unsigned alarm_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic act_q; // alarm level one cycle back
    int unsigned ack_q; // cycles of clear pulse still to go
    // a released drain line floats up to the pull-up level
    assign alarm_pin = pin_oe_n ? 1'b1 : pin_o;
    assign clear_n = !(hold_clear || ack_q != 0);
    initial begin
        act_q = 1'b0;
        ack_q = 0;
        alarm_seen = 0;
    end
    // count alarm starts; the clear pulse outlasts the 3 tick minimum
    always @(posedge clk) begin
        act_q <= (alarm_pin == PUSH_PULL);
        if (alarm_pin == PUSH_PULL && !act_q) begin
            alarm_seen <= alarm_seen + 1;
        end
        if (auto_ack && alarm_pin == PUSH_PULL && ack_q == 0) begin
            ack_q <= ACK_CYC;
        end else if (ack_q != 0) begin
            ack_q <= ack_q - 1;
        end
    end
endmodule : host_model
`default_nettype wire

// ---- verification/interval_alarm_timer_test.sv ----
`default_nettype none
module interval_alarm_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 4; // shortened 8 hz tick
    localparam int SEC = 8 * T;
    localparam int POD = 3; // shortened drain pulse
    localparam int PPP = 5; // shortened push-pull pulse
    localparam logic [3:0] ST = interval_timer_pkg::OFS_STATUS;
    localparam logic [3:0] MK = interval_timer_pkg::OFS_MASK;
    localparam logic [3:0] CT = interval_timer_pkg::OFS_COUNT;
    localparam logic [3:0] IN = interval_timer_pkg::OFS_INFO;
    logic mclk, rst, wr, rd, hold0, hold1, ack0, ack1;
    logic [1:0] sel;
    logic [3:0] addr;
    logic [31:0] wdata, rdata0, rdata1, rv0, rv1;
    logic o0, oen0, o1, oen1, irq0, irq1, clr0, clr1, pin0, pin1;
    int unsigned seen0, seen1;
    int miscompares, cmp_count;
    // pulse mode drain variant and handshake push-pull variant
    interval_alarm_timer #(.MODE(interval_timer_pkg::MODE_PULSE),
        .PUSH_PULL(1'b0), .TICK8_CYC(T), .PULSE_OD_CYC(POD),
        .PULSE_PP_CYC(PPP)) interval_alarm_timer_inst (.MCLK(mclk),
        .RST(rst), .CLEAR_N(clr0), .INTERVAL_SEL0(sel[1]),
        .INTERVAL_SEL1(sel[0]), .ALARM_O(o0), .ALARM_OE_N(oen0),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata0), .IRQ(irq0));
    interval_alarm_timer #(.MODE(interval_timer_pkg::MODE_HANDSHAKE),
        .PUSH_PULL(1'b1), .TICK8_CYC(T), .PULSE_OD_CYC(POD),
        .PULSE_PP_CYC(PPP)) interval_alarm_timer_inst2 (.MCLK(mclk),
        .RST(rst), .CLEAR_N(clr1), .INTERVAL_SEL0(sel[1]),
        .INTERVAL_SEL1(sel[0]), .ALARM_O(o1), .ALARM_OE_N(oen1),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata1), .IRQ(irq1));
    host_model #(.PUSH_PULL(1'b0), .ACK_CYC(6 * T)) host_model_inst (
        .clk(mclk), .pin_o(o0), .pin_oe_n(oen0), .hold_clear(hold0),
        .auto_ack(ack0), .clear_n(clr0), .alarm_pin(pin0),
        .alarm_seen(seen0));
    host_model #(.PUSH_PULL(1'b1), .ACK_CYC(6 * T)) host_model_inst2 (
        .clk(mclk), .pin_o(o1), .pin_oe_n(oen1), .hold_clear(hold1),
        .auto_ack(ack1), .clear_n(clr1), .alarm_pin(pin1),
        .alarm_seen(seen1));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e,
                         input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk_w
    task automatic chk_n(input int g, input int lo, input int hi,
                         input string m);
        chk_w(32'(g >= lo && g <= hi), 32'h1, m);
    endtask : chk_n
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe; taken mid-cycle
    task automatic reg_rd(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        rv0 = rdata0;
        rv1 = rdata1;
    endtask : reg_rd
    // w picks the instance; l is the alarm level awaited
    task automatic wait_a(input bit w, input logic l, input int lim,
                          output int n);
        n = 0;
        while ((w ? pin1 : !pin0) !== l && n < lim) begin
            @(negedge mclk); // pins settled mid-cycle
            n++;
        end
    endtask : wait_a
    task automatic restart0(input logic [1:0] c);
        @(posedge mclk);
        hold0 <= 1'b1;
        repeat (6 * T) @(posedge mclk);
        sel <= c;
        hold0 <= 1'b0;
    endtask : restart0
    task automatic t_reset();
        logic [3:0] a[4];
        a = '{ST, MK, CT, 4'h2};
        reg_wr(CT, 32'h00ffffff);
        foreach (a[i]) begin
            reg_rd(a[i]);
            chk_w(rv0, 32'h0, "register not zero");
        end
        chk_w({o0, oen0, o1, oen1, irq0}, 5'b01000, "pins at reset");
    endtask : t_reset
    // every code; selects flipped once latched
    task automatic t_codes();
        int iv[4] = '{60, 10, 30, 1};
        int n;
        for (int c = 0; c < 4; c++) begin
            restart0(c[1:0]);
            repeat (5 * T) @(posedge mclk);
            sel <= ~c[1:0];
            wait_a(1'b0, 1'b1, iv[c] * SEC + 8 * T, n);
            chk_n(n + 5 * T, iv[c] * SEC, iv[c] * SEC + 6 * T, "late");
            reg_rd(IN);
            chk_w(rv0[1:0], c[1:0], "latched code");
        end
    endtask : t_codes
    task automatic t_repeat();
        int n, m, s;
        s = seen0;
        wait_a(1'b0, 1'b0, 8, n);
        wait_a(1'b0, 1'b1, 2 * SEC, n);
        for (int k = 0; k < 3; k++) begin
            wait_a(1'b0, 1'b0, 8, n);
            wait_a(1'b0, 1'b1, 2 * SEC, m);
            chk_n(n, 3, 3, "pulse width");
            chk_n(n + m, SEC - 1, SEC + 2, "period");
        end
        @(negedge mclk);
        chk_n(seen0 - s, 4, 4, "pulse count");
    endtask : t_repeat
    task automatic t_early();
        restart0(2'b00);
        repeat (10 * SEC) @(posedge mclk);
        hold0 <= 1'b1;
        @(posedge mclk);
        hold0 <= 1'b0;
        repeat (4 * T) @(posedge mclk);
        reg_rd(CT);
        chk_w(32'(rv0 >= 10 && rv0 <= 11), 32'h1, "glitch seen");
        @(posedge mclk);
        hold0 <= 1'b1;
        repeat (6 * T) @(posedge mclk);
        reg_rd(CT);
        chk_w(rv0, 32'h0, "count kept");
        reg_rd(IN);
        chk_w(rv0[5:4], 2'b00, "armed while cleared");
        @(posedge mclk);
        hold0 <= 1'b0;
    endtask : t_early
    task automatic t_irq();
        repeat (6 * T) @(posedge mclk);
        reg_wr(MK, 32'h7);
        repeat (2) @(negedge mclk);
        chk_w(irq0, 1'b1, "irq not raised");
        reg_wr(MK, 32'h0);
        repeat (2) @(negedge mclk);
        chk_w(irq0, 1'b0, "irq not masked");
        reg_wr(MK, 32'h7);
        reg_wr(ST, 32'h7);
        repeat (2) @(negedge mclk);
        chk_w(irq0, 1'b0, "irq not cleared");
        reg_rd(ST);
        chk_w(rv0, 32'h0, "status kept");
    endtask : t_irq
    task automatic t_hand();
        int n, s;
        @(posedge mclk);
        sel <= 2'b11;
        hold1 <= 1'b0;
        wait_a(1'b1, 1'b1, 2 * SEC + 6 * T, n);
        repeat (2 * SEC) @(posedge mclk);
        chk_w(pin1, 1'b1, "no held alarm");
        chk_w(irq1, 1'b1, "irq not raised");
        reg_rd(CT);
        chk_w(rv1, 32'h1, "count moved");
        s = seen1;
        ack1 <= 1'b1;
        wait_a(1'b1, 1'b0, 8 * T, n);
        ack1 <= 1'b0;
        chk_w(pin1, 1'b0, "alarm kept");
        wait_a(1'b1, 1'b1, SEC + 12 * T, n);
        chk_n(n, SEC, SEC + 12 * T - 1, "no restart");
        @(negedge mclk);
        chk_n(seen1 - s, 1, 1, "alarm missed");
    endtask : t_hand
    task automatic finish_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // watchdog well past the expected 4200 cycles or so
    initial begin
        repeat (12000) @(posedge mclk);
        miscompares++;
        finish_test();
    end
    initial begin
        {rst, hold0, hold1, sel} = 5'h1f;
        {wr, rd, ack0, ack1, addr, wdata} = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_repeat();
        t_early();
        t_irq();
        t_hand();
        finish_test();
    end
endmodule : interval_alarm_timer_test
`default_nettype wire
